//--- src/ssw_ctrl.sv
`timescale 1ns/10ps
// Summary of operation
// R1 - hide oscillator overshoot after deep sleep wakeup behind the mask; the 2 us fast mask ends before the 6 us overshoot does
// R2 - normal-mode core supervision masks execution for 150 us after wakeup
// R3 - each core side off or in fullperf shortens the mask to 2 us
// R4 - cpu clock out of spec only from oscillator above level-dependent limit
// R5 - software sets divide-by-two before deep sleep
// R6 - software waits level-dependent cycles before restoring divide-by-one
// R7 - peripheral clock from oscillator gets no mask and may overshoot
// R8 - software may source the peripheral clock from the second crystal
// R9 - software keeps request enable, halts peripherals, waits before restart
// R10 - fullperf settle delay is 2 us; unsettled core level raises reset
// R11 - software uses normal mode before raising the core level
// R12 - interrupt within 1 us of sleep entry may leave device stuck
// R13 - stuck state cleared by software-level reset or external reset
// R14 - software waits for both settle flags low before sleep entry
// R15 - core supervisor state follows enable, fullperf, lowpower and auto bits
// R16 - supply supervisor and monitor follow the same state scheme
// R17 - slow core wakeup lengthens wakeup to the normal settle time
// R18 - software adds a normal-length delay where fast service needed
// R19 - wake mask is a counter gating the cpu clock, length by mode
module ssw_ctrl #(
   parameter int SLOW_CYC = ssw_pkg::SLOW_CYC_DEFAULT
) (
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic        software_level_reset,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic        sleep_enter,
   input  wire logic [2:0]  sleep_level,
   input  wire logic        wake_event,
   input  wire logic        vcore_ok,
   input  wire logic        cpu_src_osc,
   input  wire logic        periph_src_osc,
   input  wire logic [4:0]  osc_freq_mhz,
   output logic             cpu_clock_enable,
   output logic      [2:0]  cpu_clock_divider,
   output logic             periph_clock_request_enable,
   output logic             cpu_clock_out_of_spec,
   output logic             periph_clock_fast,
   output logic      [1:0]  core_supervisor_state,
   output logic      [1:0]  core_monitor_state,
   output logic      [1:0]  supply_supervisor_state,
   output logic      [1:0]  supply_monitor_state,
   output logic             core_settle_delay_flag,
   output logic             supply_settle_delay_flag,
   output logic             supervisor_reset_req,
   output logic             irq
);
   localparam logic [15:0] SLOW_CYC_W = 16'(SLOW_CYC);
   localparam int T_MASK = 0;
   localparam int T_OVER = 1;
   localparam int T_CSET = 2;
   localparam int T_SSET = 3;

   // ****************************************************
   // state
   // ****************************************************
   typedef struct packed {
      ssw_pkg::ssw_mode_t          mode;
      logic [2:0]                  lp_level;
      logic [5:0]                  core_ctl;
      logic [5:0]                  supp_ctl;
      logic [2:0]                  div;
      logic                        req_en;
      logic [1:0]                  level;
      logic [5:0]                  win_cnt;
      logic [ssw_pkg::NUM_EVT-1:0] ist;
      logic [ssw_pkg::NUM_EVT-1:0] ien;
      logic [15:0]                 rdata;
      logic [1:0]                  wake_sync;
      logic [1:0]                  vok_sync;
      logic                        reset_req;
      logic                        cpu_en;
      logic                        cpu_oos;
      logic                        per_fast;
      logic [1:0]                  cs_st;
      logic [1:0]                  cm_st;
      logic [1:0]                  ss_st;
      logic [1:0]                  sm_st;
   } ssw_state_t;

   ssw_state_t q_ff;
   ssw_state_t nxt_q;
   logic       clr;
   logic [3:0] t_load;
   logic [15:0] t_val [4];
   logic [3:0] t_busy;
   logic [3:0] t_done;

   assign clr = reset | software_level_reset; // [R13]

   // ****************************************************
   // timers: mask, overshoot, core settle, supply settle
   // ****************************************************
   ssw_tmr_if tmr [4] ();
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_tmr
         assign tmr[gi].load  = t_load[gi];
         assign tmr[gi].value = t_val[gi];
         assign t_busy[gi]    = tmr[gi].busy;
         assign t_done[gi]    = tmr[gi].done;
         ssw_timer u_tmr (
            .mclk (mclk),
            .clr  (clr),
            .tif  (tmr[gi])
         );
      end
   endgenerate

   // ****************************************************
   // supervisor state decode
   // ****************************************************
   function automatic logic [1:0] sup_state(input logic en, input logic fp,
                                            input logic lp_on,
                                            input logic auto_c,
                                            input logic asleep);
      logic [1:0] st;
      if (!en) begin
         st = ssw_pkg::SUP_OFF;
      end else if (!asleep) begin
         st = fp ? ssw_pkg::SUP_FULLPERF : ssw_pkg::SUP_NORMAL;
      end else if (!lp_on) begin
         st = ssw_pkg::SUP_OFF;
      end else if (auto_c) begin
         st = fp ? ssw_pkg::SUP_NORMAL : ssw_pkg::SUP_OFF;
      end else begin
         st = fp ? ssw_pkg::SUP_FULLPERF : ssw_pkg::SUP_NORMAL;
      end
      return st;
   endfunction

   logic       asleep;
   logic       c_sen, c_sfp, c_men, c_mfp;
   logic       s_sen, s_sfp, s_lp, s_men, s_mfp, s_auto;
   logic       core_slow;
   logic       hazard;
   logic       over_limit;
   logic [4:0] limit;
   logic       wr_core, wr_supp, wr_level;
   logic       wake_s;

   always_comb begin
      asleep = (q_ff.mode == ssw_pkg::M_SLEEP) ||
               (q_ff.mode == ssw_pkg::M_STUCK);
      c_sen  = q_ff.core_ctl[ssw_pkg::SUP_EN_BIT];
      c_sfp  = q_ff.core_ctl[ssw_pkg::SUP_FP_BIT];
      c_men  = q_ff.core_ctl[ssw_pkg::MON_EN_BIT];
      c_mfp  = q_ff.core_ctl[ssw_pkg::MON_FP_BIT];
      s_sen  = q_ff.supp_ctl[ssw_pkg::SUP_EN_BIT];
      s_sfp  = q_ff.supp_ctl[ssw_pkg::SUP_FP_BIT];
      s_lp   = q_ff.supp_ctl[ssw_pkg::SUP_LP_BIT];
      s_men  = q_ff.supp_ctl[ssw_pkg::MON_EN_BIT];
      s_mfp  = q_ff.supp_ctl[ssw_pkg::MON_FP_BIT];
      s_auto = q_ff.supp_ctl[ssw_pkg::AUTO_BIT];
      // either core side in normal mode gives slow wakeup
      core_slow = (c_sen && !c_sfp) || (c_men && !c_mfp); // [R3] [R17]
      // configurations that can hang on an early interrupt
      hazard = ((!c_sen || c_sfp || !c_men || c_mfp) &&
                ((s_sen && !s_sfp && (!s_lp || s_auto)) ||
                 (s_men && !s_mfp && s_auto))) ||
               t_busy[T_CSET] || t_busy[T_SSET]; // [R12]
      case (q_ff.level)
         2'h0:    limit = ssw_pkg::LIMIT_MHZ_L0;
         2'h1:    limit = ssw_pkg::LIMIT_MHZ_L1;
         2'h2:    limit = ssw_pkg::LIMIT_MHZ_L2;
         default: limit = ssw_pkg::LIMIT_MHZ_L3;
      endcase
      over_limit = osc_freq_mhz > limit; // [R4]
      wr_core  = reg_wr && (reg_addr == ssw_pkg::OFS_CORE_SUP_CTL);
      wr_supp  = reg_wr && (reg_addr == ssw_pkg::OFS_SUPPLY_SUP_CTL);
      wr_level = reg_wr && (reg_addr == ssw_pkg::OFS_CORE_LEVEL);
      wake_s   = q_ff.wake_sync[1];
   end

   // ****************************************************
   // next state
   // ****************************************************
   always_comb begin
      nxt_q = q_ff;
      t_load = 4'h0;
      t_val[T_MASK] = core_slow ? SLOW_CYC_W
                                : ssw_pkg::FAST_MASK_CYC; // [R2] [R3] [R19]
      t_val[T_OVER] = ssw_pkg::OVERSHOOT_CYC; // [R1]
      nxt_q.wake_sync = {q_ff.wake_sync[0], wake_event};
      nxt_q.vok_sync  = {q_ff.vok_sync[0], vcore_ok};
      nxt_q.reset_req = 1'b0;

      // register writes
      if (wr_core) begin
         nxt_q.core_ctl = reg_wdata[5:0];
      end
      if (wr_supp) begin
         nxt_q.supp_ctl = reg_wdata[5:0];
      end
      if (reg_wr && (reg_addr == ssw_pkg::OFS_CLK_DIV_CTL)) begin
         nxt_q.div = reg_wdata[2:0];
      end
      if (reg_wr && (reg_addr == ssw_pkg::OFS_CLK_REQ_CTL)) begin
         nxt_q.req_en = reg_wdata[0];
      end
      if (wr_level) begin
         nxt_q.level = reg_wdata[1:0];
      end
      if (reg_wr && (reg_addr == ssw_pkg::OFS_INT_ENABLE)) begin
         nxt_q.ien = reg_wdata[ssw_pkg::NUM_EVT-1:0];
      end
      if (reg_wr && (reg_addr == ssw_pkg::OFS_INT_CLEAR)) begin
         nxt_q.ist = q_ff.ist & ~reg_wdata[ssw_pkg::NUM_EVT-1:0];
      end
      t_val[T_CSET] = nxt_q.core_ctl[ssw_pkg::SUP_FP_BIT] ?
                      ssw_pkg::FAST_SETTLE_CYC : SLOW_CYC_W; // [R10]
      t_val[T_SSET] = nxt_q.supp_ctl[ssw_pkg::SUP_FP_BIT] ?
                      ssw_pkg::FAST_SETTLE_CYC : SLOW_CYC_W;
      // core settle delay restarts on control or level write, supply settle delay on supply control write
      t_load[T_CSET] = wr_core || wr_level; // [R10]
      t_load[T_SSET] = wr_supp;

      // settle expiry with core not yet at level
      if (t_done[T_CSET] && c_sen && !q_ff.vok_sync[1]) begin
         nxt_q.reset_req = 1'b1; // [R10]
      end

      // power mode sequencing
      if (q_ff.win_cnt != 6'h00) begin
         nxt_q.win_cnt = q_ff.win_cnt - 6'h01;
      end
      case (q_ff.mode)
         ssw_pkg::M_ACTIVE: begin
            if (sleep_enter && (sleep_level >= 3'h2) &&
                (sleep_level <= 3'h4)) begin
               nxt_q.mode     = ssw_pkg::M_SLEEP;
               nxt_q.lp_level = sleep_level;
               nxt_q.win_cnt  = ssw_pkg::ENTRY_WINDOW_CYC; // [R12]
            end
         end
         ssw_pkg::M_SLEEP: begin
            if (wake_s) begin
               if ((q_ff.win_cnt != 6'h00) && hazard) begin
                  nxt_q.mode = ssw_pkg::M_STUCK; // [R12]
               end else begin
                  nxt_q.mode = ssw_pkg::M_WAKE;
                  t_load[T_MASK] = 1'b1; // [R19]
                  t_load[T_OVER] = (q_ff.lp_level != 3'h2); // [R1] [R7]
               end
            end
         end
         ssw_pkg::M_WAKE: begin
            if (t_done[T_MASK]) begin
               nxt_q.mode = ssw_pkg::M_ACTIVE; // [R19]
            end
         end
         ssw_pkg::M_STUCK: begin
            // only a reset leaves this state
            nxt_q.mode = ssw_pkg::M_STUCK; // [R13]
         end
         default: begin
            nxt_q.mode = ssw_pkg::M_ACTIVE;
         end
      endcase

      // sticky events, set wins over clear
      if (t_done[T_MASK]) begin
         nxt_q.ist[ssw_pkg::EVT_WAKE_DONE] = 1'b1;
      end
      if (t_done[T_CSET]) begin
         nxt_q.ist[ssw_pkg::EVT_CORE_SET] = 1'b1;
      end
      if (t_done[T_SSET]) begin
         nxt_q.ist[ssw_pkg::EVT_SUPP_SET] = 1'b1;
      end
      if (nxt_q.reset_req) begin
         nxt_q.ist[ssw_pkg::EVT_RESET_REQ] = 1'b1;
      end
      if ((nxt_q.mode == ssw_pkg::M_STUCK) &&
          (q_ff.mode != ssw_pkg::M_STUCK)) begin
         nxt_q.ist[ssw_pkg::EVT_STUCK] = 1'b1;
      end

      // registered outputs
      nxt_q.cpu_en = (nxt_q.mode == ssw_pkg::M_ACTIVE); // [R2] [R19]
      // visible only once the mask is gone and div is one
      nxt_q.cpu_oos = t_busy[T_OVER] && cpu_src_osc && over_limit &&
                      (q_ff.div == ssw_pkg::CLK_DIV_BY1) &&
                      (q_ff.mode == ssw_pkg::M_ACTIVE); // [R1] [R4]
      nxt_q.per_fast = t_busy[T_OVER] && periph_src_osc; // [R7]
      nxt_q.cs_st = sup_state(c_sen, c_sfp,
                              q_ff.core_ctl[ssw_pkg::SUP_LP_BIT],
                              q_ff.core_ctl[ssw_pkg::AUTO_BIT],
                              asleep); // [R15]
      nxt_q.cm_st = sup_state(c_men, c_mfp, 1'b1,
                              q_ff.core_ctl[ssw_pkg::AUTO_BIT],
                              asleep); // [R15]
      nxt_q.ss_st = sup_state(s_sen, s_sfp, s_lp, s_auto, asleep); // [R16]
      nxt_q.sm_st = sup_state(s_men, s_mfp, 1'b1, s_auto, asleep); // [R16]

      // read port
      nxt_q.rdata = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            ssw_pkg::OFS_CORE_SUP_CTL:   nxt_q.rdata = {10'h000, q_ff.core_ctl};
            ssw_pkg::OFS_SUPPLY_SUP_CTL: nxt_q.rdata = {10'h000, q_ff.supp_ctl};
            ssw_pkg::OFS_CLK_DIV_CTL:    nxt_q.rdata = {13'h0000, q_ff.div};
            ssw_pkg::OFS_CLK_REQ_CTL:    nxt_q.rdata = {15'h0000, q_ff.req_en};
            ssw_pkg::OFS_CORE_LEVEL:     nxt_q.rdata = {14'h0000, q_ff.level};
            ssw_pkg::OFS_POWER_FLAGS: begin
               nxt_q.rdata = {14'h0000, t_busy[T_SSET], t_busy[T_CSET]};
            end
            ssw_pkg::OFS_INT_STATUS:     nxt_q.rdata = {11'h000, q_ff.ist};
            ssw_pkg::OFS_INT_ENABLE:     nxt_q.rdata = {11'h000, q_ff.ien};
            default:                     nxt_q.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (clr) begin
         q_ff          <= '0;
         q_ff.mode     <= ssw_pkg::M_ACTIVE;
         q_ff.core_ctl <= ssw_pkg::SUP_CTL_RESET;
         q_ff.supp_ctl <= ssw_pkg::SUP_CTL_RESET;
         q_ff.div      <= ssw_pkg::CLK_DIV_RESET;
         q_ff.req_en   <= ssw_pkg::CLK_REQ_RESET;
         q_ff.cpu_en   <= 1'b1;
      end else begin
         q_ff <= nxt_q;
      end
   end

   // ****************************************************
   // outputs
   // ****************************************************
   assign reg_rdata                   = q_ff.rdata;
   assign cpu_clock_enable            = q_ff.cpu_en;
   assign cpu_clock_divider           = q_ff.div;
   assign periph_clock_request_enable = q_ff.req_en;
   assign cpu_clock_out_of_spec       = q_ff.cpu_oos;
   assign periph_clock_fast           = q_ff.per_fast;
   assign core_supervisor_state       = q_ff.cs_st;
   assign core_monitor_state          = q_ff.cm_st;
   assign supply_supervisor_state     = q_ff.ss_st;
   assign supply_monitor_state        = q_ff.sm_st;
   assign core_settle_delay_flag      = t_busy[T_CSET];
   assign supply_settle_delay_flag    = t_busy[T_SSET];
   assign supervisor_reset_req        = q_ff.reset_req;
   assign irq                         = |(q_ff.ist & q_ff.ien);
endmodule

//--- src/ssw_pkg.sv
package ssw_pkg;

   // ****************************************************
   // clock and timing
   // ****************************************************
   localparam int CLK_MHZ         = 50;
   localparam int OVERSHOOT_NS    = 6000;
   localparam int FAST_MASK_NS    = 2000;
   localparam int SLOW_MASK_NS    = 150000;
   localparam int FAST_SETTLE_NS  = 2000;
   localparam int ENTRY_WINDOW_NS = 1000;
   localparam logic [15:0] OVERSHOOT_CYC =
      16'((OVERSHOOT_NS * CLK_MHZ + 999) / 1000);
   localparam logic [15:0] FAST_MASK_CYC =
      16'((FAST_MASK_NS * CLK_MHZ + 999) / 1000);
   localparam logic [15:0] FAST_SETTLE_CYC =
      16'((FAST_SETTLE_NS * CLK_MHZ + 999) / 1000);
   localparam logic [5:0] ENTRY_WINDOW_CYC =
      6'((ENTRY_WINDOW_NS * CLK_MHZ + 999) / 1000);
   localparam int SLOW_CYC_DEFAULT = (SLOW_MASK_NS * CLK_MHZ + 999) / 1000;

   // ****************************************************
   // register offsets
   // ****************************************************
   localparam logic [7:0] OFS_CORE_SUP_CTL  = 8'h00;
   localparam logic [7:0] OFS_SUPPLY_SUP_CTL = 8'h04;
   localparam logic [7:0] OFS_CLK_DIV_CTL   = 8'h08;
   localparam logic [7:0] OFS_CLK_REQ_CTL   = 8'h0C;
   localparam logic [7:0] OFS_CORE_LEVEL    = 8'h10;
   localparam logic [7:0] OFS_POWER_FLAGS   = 8'h14;
   localparam logic [7:0] OFS_INT_STATUS    = 8'h18;
   localparam logic [7:0] OFS_INT_ENABLE    = 8'h1C;
   localparam logic [7:0] OFS_INT_CLEAR     = 8'h20;

   // ****************************************************
   // supervisor control fields (same layout both sides)
   // ****************************************************
   localparam int SUP_EN_BIT  = 0;
   localparam int SUP_FP_BIT  = 1;
   localparam int SUP_LP_BIT  = 2;
   localparam int MON_EN_BIT  = 3;
   localparam int MON_FP_BIT  = 4;
   localparam int AUTO_BIT    = 5;
   localparam logic [5:0] SUP_CTL_RESET = 6'h09;
   localparam logic [2:0] CLK_DIV_RESET = 3'h0;
   localparam logic [2:0] CLK_DIV_BY1   = 3'h0;
   localparam logic       CLK_REQ_RESET = 1'b1;

   // ****************************************************
   // interrupt events and frequency limits
   // ****************************************************
   localparam int NUM_EVT       = 5;
   localparam int EVT_WAKE_DONE = 0;
   localparam int EVT_CORE_SET  = 1;
   localparam int EVT_SUPP_SET  = 2;
   localparam int EVT_RESET_REQ = 3;
   localparam int EVT_STUCK     = 4;
   localparam logic [4:0] LIMIT_MHZ_L0 = 5'h04;
   localparam logic [4:0] LIMIT_MHZ_L1 = 5'h07;
   localparam logic [4:0] LIMIT_MHZ_L2 = 5'h0B;
   localparam logic [4:0] LIMIT_MHZ_L3 = 5'h0E;

   typedef enum logic [1:0] {SUP_OFF, SUP_NORMAL, SUP_FULLPERF} ssw_sup_t;
   typedef enum logic [1:0] {M_ACTIVE, M_SLEEP, M_WAKE, M_STUCK} ssw_mode_t;

endpackage

//--- src/ssw_timer.sv
`timescale 1ns/10ps
module ssw_timer (
   input  wire logic mclk,
   input  wire logic clr,
   ssw_tmr_if.timer  tif
);
   typedef struct packed {
      logic [15:0] cnt;
      logic        done;
   } ssw_tmr_state_t;

   ssw_tmr_state_t q_ff;
   ssw_tmr_state_t nxt_q;

   always_comb begin
      nxt_q = q_ff;
      nxt_q.done = 1'b0;
      if (tif.load) begin
         nxt_q.cnt = tif.value;
      end else if (q_ff.cnt != 16'h0000) begin
         nxt_q.cnt = q_ff.cnt - 16'h0001;
         nxt_q.done = (q_ff.cnt == 16'h0001);
      end
   end

   always_ff @(posedge mclk) begin
      if (clr) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign tif.busy = (q_ff.cnt != 16'h0000);
   assign tif.done = q_ff.done;
endmodule

//--- src/ssw_tmr_if.sv
`timescale 1ns/10ps
interface ssw_tmr_if;
   logic        load;
   logic [15:0] value;
   logic        busy;
   logic        done;
   modport owner (output load, output value, input busy, input done);
   modport timer (input load, input value, output busy, output done);
endinterface

//--- verification/ssw_ctrl_assertions.sv
`timescale 1ns/10ps
// ****************************************************
// port checker
// ****************************************************
module ssw_ctrl_assertions #(
   parameter int SLOW_CYC = 200
) (
   input wire logic        mclk,
   input wire logic        reset,
   input wire logic        software_level_reset,
   input wire logic [7:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        sleep_enter,
   input wire logic [2:0]  sleep_level,
   input wire logic        cpu_src_osc,
   input wire logic        periph_src_osc,
   input wire logic        cpu_clock_enable,
   input wire logic [2:0]  cpu_clock_divider,
   input wire logic        periph_clock_fast,
   input wire logic        cpu_clock_out_of_spec,
   input wire logic        core_settle_delay_flag,
   input wire logic        supply_settle_delay_flag,
   input wire logic        supervisor_reset_req
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset || software_level_reset);
   logic [15:0] cnt_ff;
   wire         core_wr = reg_wr && (reg_addr == 8'h00 || reg_addr == 8'h10);
   // cycles since the last write that loads the core settle timer
   always_ff @(posedge mclk) begin
      if (core_wr) begin
         cnt_ff <= 16'h0000;
      end else if (cnt_ff != 16'hFFFF) begin
         cnt_ff <= cnt_ff + 16'h0001;
      end
   end
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not zero outside read slot");
   a_sleep_gate: assert property (
      sleep_enter && sleep_level inside {3'h2, 3'h3, 3'h4} && cpu_clock_enable
      |-> ##2 !cpu_clock_enable [*8])
      else $error("cpu clock not gated after sleep entry");
   a_core_settle: assert property (
      core_wr |=> core_settle_delay_flag [*8])
      else $error("core settle flag not raised by write");
   a_supply_settle: assert property (
      reg_wr && reg_addr == 8'h04 |=> supply_settle_delay_flag [*8])
      else $error("supply settle flag not raised by write");
   a_settle_len: assert property (
      $fell(core_settle_delay_flag)
      |-> cnt_ff == ssw_pkg::FAST_SETTLE_CYC || cnt_ff == 16'(SLOW_CYC))
      else $error("core settle flag length wrong");
   a_req_pulse: assert property (
      supervisor_reset_req |=> !supervisor_reset_req)
      else $error("reset request longer than one cycle");
   a_req_cause: assert property (
      supervisor_reset_req |-> $past(core_settle_delay_flag)
      || $past(core_settle_delay_flag, 2) || $past(core_settle_delay_flag, 3))
      else $error("reset request without settle expiry");
   a_div_follow: assert property (
      reg_wr && reg_addr == 8'h08
      |=> cpu_clock_divider == $past(reg_wdata[2:0]))
      else $error("divider port does not follow write");
   a_periph_src: assert property (
      periph_clock_fast |-> $past(periph_src_osc))
      else $error("peripheral overshoot without oscillator source");
   a_spec_src: assert property (
      cpu_clock_out_of_spec |-> $past(cpu_src_osc))
      else $error("cpu out of spec without oscillator source");
   c_sleep: cover property (sleep_enter && cpu_clock_enable);
   c_reset_req: cover property (supervisor_reset_req);
   c_periph_fast: cover property (periph_clock_fast);
endmodule

bind ssw_ctrl ssw_ctrl_assertions #(.SLOW_CYC(SLOW_CYC)) u_chk (
   .mclk(mclk), .reset(reset), .software_level_reset(software_level_reset),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_enter(sleep_enter),
   .sleep_level(sleep_level), .cpu_src_osc(cpu_src_osc),
   .periph_src_osc(periph_src_osc), .cpu_clock_enable(cpu_clock_enable),
   .cpu_clock_divider(cpu_clock_divider),
   .periph_clock_fast(periph_clock_fast),
   .cpu_clock_out_of_spec(cpu_clock_out_of_spec),
   .core_settle_delay_flag(core_settle_delay_flag),
   .supply_settle_delay_flag(supply_settle_delay_flag),
   .supervisor_reset_req(supervisor_reset_req));

//--- verification/ssw_ctrl_bench.sv
`timescale 1ns/10ps
module ssw_ctrl_bench;
   localparam int SLOW = 200;
   logic        mclk = 1'b0;
   logic        reset = 1'b1;
   logic        swr = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        slp = 1'b0;
   logic [2:0]  lvl = 3'h0;
   logic        wake = 1'b0;
   logic        vok = 1'b1;
   logic [4:0]  freq = 5'h14;
   logic [15:0] rdata, r;
   logic        cen, oos, pfast, csf, ssf, rreq, irq, preq;
   logic [2:0]  div;
   logic [1:0]  css, cms, sss, sms, src = 2'h3;
   int          error_cnt = 0;
   int          cmp_count = 0, n;
   integer      seed = 32'ha3033c8c;
   logic [7:0]  ra[10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
                           8'h1C, 8'h20, 8'h24};
   logic [15:0] rv[10] = '{16'h0009, 16'h0009, 16'h0000, 16'h0001, 16'h0000,
                           16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
   logic [5:0]  cfg[4] = '{6'h00, 6'h1F, 6'h09, 6'h0B};
   logic [2:0]  lv[4] = '{3'h3, 3'h4, 3'h2, 3'h3};
   ssw_ctrl #(.SLOW_CYC(SLOW)) DUT (
      .mclk(mclk), .reset(reset), .software_level_reset(swr),
      .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
      .reg_rdata(rdata), .sleep_enter(slp), .sleep_level(lvl),
      .wake_event(wake), .vcore_ok(vok), .cpu_src_osc(src[0]),
      .periph_src_osc(src[1]), .osc_freq_mhz(freq), .cpu_clock_enable(cen),
      .cpu_clock_divider(div), .periph_clock_request_enable(preq),
      .cpu_clock_out_of_spec(oos), .periph_clock_fast(pfast),
      .core_supervisor_state(css), .core_monitor_state(cms),
      .supply_supervisor_state(sss), .supply_monitor_state(sms),
      .core_settle_delay_flag(csf), .supply_settle_delay_flag(ssf),
      .supervisor_reset_req(rreq), .irq(irq));
   always #10 mclk = ~mclk;
   // ****************************************************
   // helpers
   // ****************************************************
   task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
      cmp_count++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic cyc(int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask
   task automatic wr_reg(logic [7:0] a, logic [15:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_chk(string nm, logic [7:0] a, logic [15:0] e);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      chk(nm, e, rdata);
   endtask
   task automatic settle(output int k);
      k = 0;
      while ((csf | ssf) !== 1'b0 && k < 1000) begin
         cyc(1);
         k++;
      end
   endtask
   function automatic logic [1:0] st(logic [5:0] c, logic lp);
      if (!c[0] || (lp && !c[2])) return 2'h0;
      if (lp && c[5]) return c[1] ? 2'h1 : 2'h0;
      return c[1] ? 2'h2 : 2'h1;
   endfunction
   function automatic int msk(logic [5:0] c);
      if ((!c[0] && !c[3]) || (c[0] && c[1] && c[3] && c[4])) return 100;
      return SLOW;
   endfunction
   task automatic conclude();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #200000;
      error_cnt++;
      conclude();
   end
   // ****************************************************
   // scenarios
   // ****************************************************
   initial begin
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      cyc(2);
      chk("states", 16'({css, cms, sss, sms}), 16'h0055);
      for (int i = 0; i < 10; i++) rd_chk("reset_val", ra[i], rv[i]);
      for (int i = 0; i < 8; i++) begin
         r = 16'($random(seed));
         wr_reg(8'h08, r);
         wr_reg(8'h0C, r);
         wr_reg(8'h14, r);
         rd_chk("div", 8'h08, 16'(r[2:0]));
         chk("req", 16'(r[0]), 16'(preq));
         rd_chk("flags_ro", 8'h14, 16'h0000);
      end
      wr_reg(8'h0C, 16'h0001);
      wr_reg(8'h1C, 16'h0002);
      wr_reg(8'h00, 16'h000B);
      settle(n);
      chk("fast_settle", 16'h0064, 16'(n));
      cyc(1);
      chk("irq_on", 16'h0001, 16'(irq));
      wr_reg(8'h20, 16'h0002);
      wr_reg(8'h1C, 16'h0000);
      chk("irq_clr", 16'h0000, 16'(irq));
      wr_reg(8'h00, 16'h0009);
      settle(n);
      chk("slow_settle", 16'(SLOW), 16'(n));
      chk("irq_mask", 16'h0000, 16'(irq));
      rd_chk("status", 8'h18, 16'h0002);
      wr_reg(8'h1C, 16'h0002);
      chk("irq_en", 16'h0001, 16'(irq));
      wr_reg(8'h04, 16'h0009);
      settle(n);
      vok <= 1'b0;
      wr_reg(8'h00, 16'h000B);
      settle(n);
      r = 16'h0000;
      repeat (8) begin
         r = r | 16'(rreq);
         cyc(1);
      end
      chk("reset_req", 16'h0001, r);
      vok <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr_reg(8'h08, 16'(i == 3));
         wr_reg(8'h00, 16'(cfg[i]));
         settle(n);
         chk("core_act", 16'(st(cfg[i], 1'b0)), 16'(css));
         @(posedge mclk);
         slp <= 1'b1;
         lvl <= lv[i];
         src <= {i != 0, i != 1};
         @(posedge mclk);
         slp <= 1'b0;
         cyc(60);
         chk("core_lp", 16'(st(cfg[i], 1'b1)), 16'(css));
         chk("supply_lp", 16'h0000, 16'(sss));
         @(posedge mclk);
         wake <= 1'b1;
         n = 0;
         while (cen !== 1'b1 && n < 1000) begin
            cyc(1);
            n++;
         end
         r = 16'(n >= msk(cfg[i]) + 2 && n <= msk(cfg[i]) + 8);
         chk("mask_len", 16'h0001, r);
         cyc(1);
         chk("oos", 16'(lv[i] != 3'h2 && i != 3 && src[0]), 16'(oos));
         chk("pfast", 16'(lv[i] != 3'h2 && src[1]), 16'(pfast));
         wake <= 1'b0;
      end
      wr_reg(8'h00, 16'h0000);
      settle(n);
      wr_reg(8'h08, 16'h0000);
      @(posedge mclk);
      slp <= 1'b1;
      lvl <= 3'h4;
      @(posedge mclk);
      slp <= 1'b0;
      cyc(10);
      wake <= 1'b1;
      cyc(400);
      chk("stuck", 16'h0000, 16'(cen));
      wake <= 1'b0;
      swr <= 1'b1;
      cyc(1);
      swr <= 1'b0;
      cyc(2);
      chk("unstuck", 16'h0001, 16'(cen));
      rd_chk("ctl_after_swr", 8'h00, 16'h0009);
      conclude();
   end
endmodule
